// [rtl/itp_pkg.sv]
// Constants for the interrupt test and priority promotion register set.
// Assumes a 32-bit Avalon-MM slave; registers sit in the low byte lanes.
package itp_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_TEST_CTRL = 6'h15;
   localparam logic [5:0] IDX_FORCE     = 6'h16;
   localparam logic [5:0] IDX_PROMOTE   = 6'h1F;
   localparam logic [5:0] IDX_STATUS    = 6'h20;
   localparam logic [5:0] IDX_MASK      = 6'h21;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int         WREN_BIT      = 4;
   localparam int         BANK_MSB      = 3;
   localparam int         PSEL_LSB      = 1;
   localparam logic [7:0] PROMOTE_RST   = 8'hF2;
   localparam logic [3:0] BANK_RST      = 4'h0;
   localparam logic [3:0] TOP_BANK      = 4'hF;
   localparam logic [7:0] TOP_BANK_BITS = 8'h07;
   localparam int         EV_REFUSED    = 0;
   localparam int         EV_VECTOR     = 1;
   localparam int         NUM_EV        = 2;

   // ---------------------------------------------------------------
   // Source map: index i is vector 0xFF00 + 2*i
   // ---------------------------------------------------------------
   localparam int          NUM_BANKS   = 16;
   localparam int          BANK_W      = 8;
   localparam int          NUM_SRC     = NUM_BANKS * BANK_W;
   localparam logic [15:0] IMPL_BANKS  = 16'h800F;
   localparam logic [6:0]  IDX_XIRQ    = 7'h7A;
   localparam logic [6:0]  IDX_IRQ     = 7'h79;
   localparam logic [6:0]  IDX_TICK    = 7'h78;
   localparam logic [7:0]  VEC_HIGH    = 8'hFF;
   localparam logic [15:0] VEC_SWI     = 16'hFFF6;

endpackage : itp_pkg

// [rtl/itp_regs.sv]
// Interrupt test control, force banks, promotion and priority decoder.
// Assumes requests and CPU state inputs come from logic on clk_sys.
`timescale 1ns/1ps

module itp_regs (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [127:0] int_req,
   input  wire logic        special_mode,
   input  wire logic        ccr_i_mask,
   input  wire logic        ccr_x_mask,
   input  wire logic        vec_req,
   output logic [15:0]      vec_addr,
   output logic             vec_valid,
   output logic [127:0]     decoder_req,
   output logic             irq
);

   // ---------------------------------------------------------------
   // Bus handshake: one wait state per access
   // ---------------------------------------------------------------
   logic        ack_q, ack_d;
   logic        acc;
   logic [5:0]  idx;
   logic        wr_lo;

   assign acc             = avs_read | avs_write;
   assign idx             = avs_address[7:2];
   assign wr_lo           = avs_write & ack_q & avs_byteenable[0];
   assign avs_waitrequest = acc & ~ack_q;

   always_comb begin
      ack_d = acc & ~ack_q;
   end

   // ---------------------------------------------------------------
   // Source validity per bank
   // ---------------------------------------------------------------
   logic [127:0] valid;
   genvar gb;
   generate
      for (gb = 0; gb < itp_pkg::NUM_BANKS; gb++) begin : g_bank
         localparam logic [3:0] BNK = 4'(gb);
         assign valid[gb*8 +: 8] = !itp_pkg::IMPL_BANKS[gb] ? 8'h00 :
            (BNK == itp_pkg::TOP_BANK) ? itp_pkg::TOP_BANK_BITS : 8'hFF;
      end
   endgenerate

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic        wren_q, wren_d;
   logic [3:0]  bank_q, bank_d;
   logic [7:0]  prom_q, prom_d;
   logic [127:0] test_q, test_d;
   logic [1:0]  stat_q, stat_d;
   logic [1:0]  mask_q, mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  ev;
   logic        bank_ok;
   logic [7:0]  bank_valid;
   logic [7:0]  bank_live;
   logic [7:0]  bank_test;
   logic        ctrl_ok;
   logic        force_ok;
   logic        prom_ok;
   logic        vec_fire;

   assign bank_valid = valid[bank_q*8 +: 8];
   assign bank_ok    = itp_pkg::IMPL_BANKS[bank_q];
   assign bank_live  = int_req[bank_q*8 +: 8] & bank_valid;
   assign bank_test  = test_q[bank_q*8 +: 8];
   assign ctrl_ok    = special_mode & ccr_i_mask & ccr_x_mask;
   assign force_ok   = special_mode & wren_q & ccr_i_mask & bank_ok;
   assign prom_ok    = ccr_i_mask;

   always_comb begin
      wren_d = wren_q;
      bank_d = bank_q;
      prom_d = prom_q;
      test_d = test_q;
      mask_d = mask_q;
      ev     = '0;
      ev[itp_pkg::EV_VECTOR] = vec_fire;
      if (wr_lo && idx == itp_pkg::IDX_TEST_CTRL) begin
         bank_d = avs_writedata[itp_pkg::BANK_MSB:0];
         if (ctrl_ok) begin
            wren_d = avs_writedata[itp_pkg::WREN_BIT];
         end else begin
            ev[itp_pkg::EV_REFUSED] = 1'b1;
         end
      end
      // Snapshot keeps pending requests alive across the switch
      if (wren_d && !wren_q) begin
         test_d = int_req & valid;
      end
      if (wr_lo && idx == itp_pkg::IDX_FORCE) begin
         if (force_ok) begin
            test_d[bank_q*8 +: 8] = avs_writedata[7:0] & bank_valid;
         end else begin
            ev[itp_pkg::EV_REFUSED] = 1'b1;
         end
      end
      if (wr_lo && idx == itp_pkg::IDX_PROMOTE) begin
         if (prom_ok) begin
            prom_d = {avs_writedata[7:1], 1'b0};
         end else begin
            ev[itp_pkg::EV_REFUSED] = 1'b1;
         end
      end
      if (wr_lo && idx == itp_pkg::IDX_MASK) begin
         mask_d = avs_writedata[itp_pkg::NUM_EV-1:0];
      end
      // Set wins over write-one-to-clear
      stat_d = stat_q;
      if (wr_lo && idx == itp_pkg::IDX_STATUS) begin
         stat_d = stat_q & ~avs_writedata[itp_pkg::NUM_EV-1:0];
      end
      stat_d = stat_d | ev;
   end

   // ---------------------------------------------------------------
   // Read mux, loaded in the wait cycle
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      if (avs_read && !ack_q) begin
         rdata_d = '0;
         unique case (idx)
            itp_pkg::IDX_TEST_CTRL: begin
               rdata_d[itp_pkg::WREN_BIT]   = wren_q;
               rdata_d[itp_pkg::BANK_MSB:0] = bank_q;
            end
            itp_pkg::IDX_FORCE: begin
               if (special_mode && bank_ok) begin
                  rdata_d[7:0] = wren_q ? bank_test : bank_live;
               end
            end
            itp_pkg::IDX_PROMOTE: rdata_d[7:0] = prom_q;
            itp_pkg::IDX_STATUS: rdata_d[itp_pkg::NUM_EV-1:0] = stat_q;
            itp_pkg::IDX_MASK: rdata_d[itp_pkg::NUM_EV-1:0] = mask_q;
            default: rdata_d = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Priority decoder
   // ---------------------------------------------------------------
   logic [6:0]  psel;
   logic [6:0]  prom_idx;
   logic        swap;
   logic        found;
   logic [6:0]  win;
   logic [6:0]  pos;
   logic [6:0]  src;
   logic [15:0] vec_q, vec_d;
   logic [15:0] last_q, last_d;
   logic        vvld_q, vvld_d;

   assign decoder_req = (wren_q ? test_q : int_req) & valid;
   assign psel        = prom_q[7:itp_pkg::PSEL_LSB];
   assign prom_idx    = (psel > itp_pkg::IDX_IRQ || !valid[psel]) ?
                        itp_pkg::IDX_IRQ : psel;
   assign swap        = prom_idx != itp_pkg::IDX_TICK;

   always_comb begin
      found = 1'b0;
      win   = '0;
      pos   = '0;
      src   = '0;
      for (int p = 0; p < 122; p++) begin
         pos = 7'(p);
         src = (swap && pos == prom_idx) ? itp_pkg::IDX_TICK : pos;
         if (!(swap && pos == itp_pkg::IDX_TICK) && decoder_req[src]) begin
            found = 1'b1;
            win   = src;
         end
      end
      if (decoder_req[prom_idx]) begin
         found = 1'b1;
         win   = prom_idx;
      end
      if (decoder_req[itp_pkg::IDX_XIRQ]) begin
         found = 1'b1;
         win   = itp_pkg::IDX_XIRQ;
      end
   end

   assign vec_fire = vec_req;

   always_comb begin
      last_d = found ? {itp_pkg::VEC_HIGH, win, 1'b0} : last_q;
      vvld_d = vec_req;
      vec_d  = vec_q;
      if (vec_req) begin
         vec_d = last_d;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ack_q   <= 1'b0;
         wren_q  <= 1'b0;
         bank_q  <= itp_pkg::BANK_RST;
         prom_q  <= itp_pkg::PROMOTE_RST;
         test_q  <= '0;
         stat_q  <= '0;
         mask_q  <= '0;
         rdata_q <= '0;
         vec_q   <= itp_pkg::VEC_SWI;
         last_q  <= itp_pkg::VEC_SWI;
         vvld_q  <= 1'b0;
      end else begin
         ack_q   <= ack_d;
         wren_q  <= wren_d;
         bank_q  <= bank_d;
         prom_q  <= prom_d;
         test_q  <= test_d;
         stat_q  <= stat_d;
         mask_q  <= mask_d;
         rdata_q <= rdata_d;
         vec_q   <= vec_d;
         last_q  <= last_d;
         vvld_q  <= vvld_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign vec_addr     = vec_q;
   assign vec_valid    = vvld_q;
   assign irq          = |(stat_q & mask_q);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_wr_done(logic [5:0] r);
      avs_write && ack_q && avs_byteenable[0] && idx == r;
   endsequence

   sequence s_rd_done(logic [5:0] r);
      avs_read && ack_q && idx == r;
   endsequence

   a_ctrl_guard: assert property (
      s_wr_done(itp_pkg::IDX_TEST_CTRL) ##0 !ctrl_ok |=> $stable(wren_q))
      else $error("enable bit changed without permission");

   a_bank_free: assert property (
      s_wr_done(itp_pkg::IDX_TEST_CTRL) |=> bank_q == $past(avs_writedata[3:0]))
      else $error("bank select not written");

   a_force_guard: assert property (
      s_wr_done(itp_pkg::IDX_FORCE) ##0 !force_ok |=> $stable(test_q))
      else $error("force bank changed by refused write");

   a_live_path: assert property (
      !wren_q |-> decoder_req == (int_req & valid))
      else $error("decoder not fed from live inputs");

   a_pend_keep: assert property (
      $rose(wren_q) |-> test_q == ($past(int_req) & valid))
      else $error("pending requests lost on entering test");

   a_normal_zero: assert property (
      avs_read && !ack_q && idx == itp_pkg::IDX_FORCE && !special_mode
      ##1 s_rd_done(itp_pkg::IDX_FORCE) |-> avs_readdata == 32'h0)
      else $error("force read nonzero outside special mode");

   a_top_bits: assert property (
      test_q[127:123] == 5'h00)
      else $error("top bank upper bits set");

   a_prom_guard: assert property (
      s_wr_done(itp_pkg::IDX_PROMOTE) ##0 !ccr_i_mask |=> $stable(prom_q))
      else $error("promotion changed with I mask clear");

   a_xirq_first: assert property (
      vec_req && decoder_req[itp_pkg::IDX_XIRQ] |=> vec_valid && vec_addr == 16'hFFF4)
      else $error("XIRQ vector not supplied first");

   a_prom_first: assert property (
      vec_req && !decoder_req[itp_pkg::IDX_XIRQ] && decoder_req[prom_idx]
      |=> vec_addr == {8'hFF, $past(prom_idx), 1'b0})
      else $error("promoted source not top maskable");

   a_refuse_flag: assert property (
      ev[itp_pkg::EV_REFUSED] |=> stat_q[itp_pkg::EV_REFUSED]
      ##0 irq == (mask_q[0] | (stat_q[1] & mask_q[1])))
      else $error("refused write not flagged");

   a_wait_once: assert property (
      avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");

   a_vec_pulse: assert property (
      vec_req |=> vec_valid)
      else $error("vector not answered");

   a_vec_quiet: assert property (
      !vec_req |=> !vec_valid)
      else $error("vector valid without request");

   a_vec_hold: assert property (
      !vec_req |=> $stable(vec_addr))
      else $error("vector changed without request");

   a_stat_sticky: assert property (
      stat_q[itp_pkg::EV_REFUSED] && !(avs_write && ack_q
      && idx == itp_pkg::IDX_STATUS) |=> stat_q[itp_pkg::EV_REFUSED])
      else $error("status bit lost without clear");

   a_vec_stat: assert property (
      vec_req |=> stat_q[itp_pkg::EV_VECTOR])
      else $error("vector event not flagged");

   a_wren_set: assert property (
      s_wr_done(itp_pkg::IDX_TEST_CTRL) ##0 ctrl_ok
      |=> wren_q == $past(avs_writedata[itp_pkg::WREN_BIT]))
      else $error("permitted enable write lost");

   a_force_load: assert property (
      s_wr_done(itp_pkg::IDX_FORCE) ##0 force_ok
      |=> bank_test == ($past(avs_writedata[7:0]) & bank_valid))
      else $error("permitted force write lost");

   a_unimpl_zero: assert property (
      !bank_ok |-> bank_test == 8'h00)
      else $error("unimplemented bank holds a value");

   a_test_path: assert property (
      wren_q |-> decoder_req == (test_q & valid))
      else $error("decoder not fed from force banks");

   a_prom_load: assert property (
      s_wr_done(itp_pkg::IDX_PROMOTE) ##0 ccr_i_mask
      |=> prom_q == {$past(avs_writedata[7:1]), 1'b0})
      else $error("permitted promotion write lost");

   a_prom_dflt: assert property (
      psel > itp_pkg::IDX_IRQ |-> prom_idx == itp_pkg::IDX_IRQ)
      else $error("too high promotion not defaulted");

   a_rdata_hold: assert property (
      !(avs_read && !ack_q) |=> $stable(avs_readdata))
      else $error("read data changed outside a read");

endmodule : itp_regs

// [verification/itp_periph.sv]
// Peripheral request lines seen by the interrupt test registers.
// Assumes the same clock and reset as the register block.
`timescale 1ns/1ps
module itp_periph (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         raise,
   input  wire logic [6:0]   raise_idx,
   input  wire logic         drop_all,
   output logic [127:0]      int_req
);
   // Requests are level and stay up until dropped
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         int_req <= '0;
      end else if (drop_all) begin
         int_req <= '0;
      end else if (raise) begin
         int_req[raise_idx] <= 1'b1;
      end
   end
endmodule : itp_periph

// [verification/itp_regs_bench.sv]
// Self-checking bench for the interrupt test and promotion registers.
// Assumes itp_pkg and the peripheral request model are compiled first.
`timescale 1ns/1ps
module itp_regs_bench;
   logic          clk_sys = 1'b0;
   logic          reset_n = 1'b0;
   logic [7:0]    avs_address = 8'h00;
   logic          avs_read = 1'b0;
   logic          avs_write = 1'b0;
   logic [31:0]   avs_writedata = 32'h00000000;
   logic [3:0]    avs_byteenable = 4'h0;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [127:0]  int_req;
   logic          special_mode = 1'b0;
   logic          ccr_i_mask = 1'b0;
   logic          ccr_x_mask = 1'b0;
   logic          vec_req = 1'b0;
   logic [15:0]   vec_addr;
   logic          vec_valid;
   logic [127:0]  decoder_req;
   logic          irq;
   logic          raise = 1'b0;
   logic [6:0]    raise_idx = 7'h00;
   logic          drop_all = 1'b0;
   logic [31:0]   exp_rd[$];
   logic [15:0]   exp_vec[$];
   logic [31:0]   lfsr = 32'h4DE5;
   logic [7:0]    r;
   int            n_errors = 0;
   int            n_checks = 0;
   int            cycles = 0;

   always #20 clk_sys = ~clk_sys;

   itp_periph PEER (.clk_sys(clk_sys), .reset_n(reset_n), .raise(raise),
      .raise_idx(raise_idx), .drop_all(drop_all), .int_req(int_req));

   itp_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .int_req(int_req),
      .special_mode(special_mode), .ccr_i_mask(ccr_i_mask),
      .ccr_x_mask(ccr_x_mask), .vec_req(vec_req), .vec_addr(vec_addr),
      .vec_valid(vec_valid), .decoder_req(decoder_req), .irq(irq));

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic we, input logic [5:0] idx,
                      input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address    <= {idx, 2'b00};
      avs_write      <= we;
      avs_read       <= !we;
      avs_writedata  <= {24'h000000, d};
      avs_byteenable <= be;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [5:0] idx, input logic [7:0] e);
      exp_rd.push_back({24'h000000, e});
      bus(1'b0, idx, 8'h00, 4'h1);
   endtask : rd

   task automatic cpu(input logic sm, input logic im, input logic xm);
      @(posedge clk_sys);
      special_mode <= sm;
      ccr_i_mask   <= im;
      ccr_x_mask   <= xm;
   endtask : cpu

   task automatic vec(input logic [15:0] e);
      exp_vec.push_back(e);
      @(posedge clk_sys);
      vec_req <= 1'b1;
      @(posedge clk_sys);
      vec_req <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : vec

   // ---------------------------------------------------------------
   // Result watcher and timeout
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         chk(avs_readdata, exp_rd.pop_front());
      end
      if (vec_valid === 1'b1) begin
         chk({16'h0000, vec_addr}, {16'h0000, exp_vec.pop_front()});
      end
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         wrap_up;
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(itp_pkg::IDX_TEST_CTRL, 8'h00);
      rd(itp_pkg::IDX_PROMOTE, 8'hF2);
      @(posedge clk_sys);
      raise     <= 1'b1;
      raise_idx <= 7'h03;
      @(posedge clk_sys);
      raise <= 1'b0;
      rd(itp_pkg::IDX_FORCE, 8'h00);
      cpu(1'b1, 1'b1, 1'b0);
      rd(itp_pkg::IDX_FORCE, 8'h08);
      wr(itp_pkg::IDX_MASK, 8'h01);
      wr(itp_pkg::IDX_TEST_CTRL, 8'h10);
      rd(itp_pkg::IDX_TEST_CTRL, 8'h00);
      chk({31'h0, irq}, 32'h1);
      wr(itp_pkg::IDX_STATUS, 8'h01);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      cpu(1'b1, 1'b1, 1'b1);
      wr(itp_pkg::IDX_TEST_CTRL, 8'h10);
      rd(itp_pkg::IDX_TEST_CTRL, 8'h10);
      @(posedge clk_sys);
      drop_all <= 1'b1;
      @(posedge clk_sys);
      drop_all <= 1'b0;
      rd(itp_pkg::IDX_FORCE, 8'h08);
      chk({31'h0, decoder_req[3]}, 32'h1);
      bus(1'b1, itp_pkg::IDX_FORCE, 8'h55, 4'h0);
      cpu(1'b1, 1'b0, 1'b1);
      wr(itp_pkg::IDX_FORCE, 8'h81);
      rd(itp_pkg::IDX_FORCE, 8'h08);
      cpu(1'b1, 1'b1, 1'b1);
      wr(itp_pkg::IDX_FORCE, 8'h81);
      rd(itp_pkg::IDX_FORCE, 8'h81);
      chk({24'h0, decoder_req[7:0]}, 32'h81);
      cpu(1'b0, 1'b1, 1'b1);
      rd(itp_pkg::IDX_FORCE, 8'h00);
      cpu(1'b1, 1'b1, 1'b1);
      for (int b = 0; b < 16; b++) begin
         lfsr = lfsr_next(lfsr);
         r = lfsr[7:0];
         wr(itp_pkg::IDX_TEST_CTRL, {4'h1, b[3:0]});
         wr(itp_pkg::IDX_FORCE, r);
         if (!itp_pkg::IMPL_BANKS[b]) begin
            r = 8'h00;
         end else if (b[3:0] == itp_pkg::TOP_BANK) begin
            r = r & itp_pkg::TOP_BANK_BITS;
         end
         rd(itp_pkg::IDX_FORCE, r);
         wr(itp_pkg::IDX_FORCE, 8'h00);
      end
      rd(6'h30, 8'h00);
      wr(itp_pkg::IDX_TEST_CTRL, 8'h11);
      wr(itp_pkg::IDX_FORCE, 8'h03);
      wr(itp_pkg::IDX_TEST_CTRL, 8'h1F);
      wr(itp_pkg::IDX_FORCE, 8'h01);
      cpu(1'b1, 1'b0, 1'b1);
      wr(itp_pkg::IDX_PROMOTE, 8'h10);
      rd(itp_pkg::IDX_PROMOTE, 8'hF2);
      cpu(1'b1, 1'b1, 1'b1);
      wr(itp_pkg::IDX_PROMOTE, 8'h10);
      rd(itp_pkg::IDX_PROMOTE, 8'h10);
      vec(16'hFF10);
      wr(itp_pkg::IDX_TEST_CTRL, 8'h11);
      wr(itp_pkg::IDX_FORCE, 8'h02);
      vec(16'hFF12);
      wr(itp_pkg::IDX_PROMOTE, 8'hF2);
      vec(16'hFFF0);
      repeat (4) @(posedge clk_sys);
      wrap_up;
   end
endmodule : itp_regs_bench
